// ---- src/pin_select_pkg.sv ----
package pin_select_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_PORT_OUT = 8'h04;
   localparam logic [7:0] ADDR_PORT_MODE = 8'h08;
   localparam logic [7:0] ADDR_PIN_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_PIN_IN = 8'h10;
   // Config register fields
   localparam int CFG_RC_OSC_BIT = 0;
   localparam int CFG_DEBUG_EN_BIT = 1;
   localparam int CFG_RESET_FUSE_BIT = 2;
   localparam int CFG_DIV_CLOCK_EN_BIT = 3;
   localparam int CFG_PWM0_EN_BIT = 4;
   localparam int CFG_PWM1_EN_BIT = 5;
   localparam logic [5:0] CFG_RESET_VALUE = 6'h04;
   // Pin indices inside the 8-bit pin vector
   localparam int PIN_P40 = 0;
   localparam int PIN_P41 = 1;
   localparam int PIN_P32 = 2;
   localparam int PIN_P33 = 3;
   localparam int PIN_P34 = 4;
   localparam int PIN_P35 = 5;
   localparam int PIN_P36 = 6;
   localparam int PIN_P37 = 7;
   localparam int NUM_PINS = 8;
   localparam logic [7:0] PORT_OUT_RESET = 8'hff;
   // Two mode bits per pin: 0 quasi, 1 push-pull, 2 input-only, 3 open-drain
   localparam logic [15:0] PORT_MODE_RESET = 16'h0000;
   localparam logic [1:0] MODE_QUASI = 2'h0;
   localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
   localparam logic [1:0] MODE_INPUT = 2'h2;
   localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int DIV_CLOCK_RATIO = 2;
endpackage : pin_select_pkg

// ---- src/port_pin_function_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_select
   import pin_select_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   input wire logic osc_amp_out_level,
   input wire logic debug_data_out,
   input wire logic debug_data_oe,
   input wire logic pwm0_level,
   input wire logic pwm1_level,
   output logic osc_amp_in,
   output logic debug_serial_data,
   output logic debug_serial_clock,
   output logic ext_reset_n,
   output logic ext_irq_zero,
   output logic ext_irq_one,
   output logic timer0_count_pin,
   output logic timer_count_pin
);

   typedef struct packed {
      logic [5:0] cfg;
      logic [7:0] port_out;
      logic [15:0] port_mode;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic div_clk;
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
      logic osc_in;
      logic dbg_data;
      logic dbg_clk;
      logic rst_pin_n;
      logic irq0;
      logic irq1;
      logic t0_cnt;
      logic t1_cnt;
      logic aw_rdy, w_rdy, ar_rdy;
   } state_t;

   state_t state_reg;
   state_t state_next;

   localparam state_t STATE_RESET = '{
      cfg: CFG_RESET_VALUE, port_out: PORT_OUT_RESET, port_mode: PORT_MODE_RESET,
      aw_held: 1'b0, aw_addr: 8'h00, w_held: 1'b0, w_data: 32'h0000_0000,
      w_strb: 4'h0, bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0,
      rdata: 32'h0000_0000, rresp: 2'h0, div_clk: 1'b0, pin_out: 8'hff,
      pin_oe: 8'h00, osc_in: 1'b0, dbg_data: 1'b1, dbg_clk: 1'b0,
      rst_pin_n: 1'b1, irq0: 1'b1, irq1: 1'b1, t0_cnt: 1'b0, t1_cnt: 1'b0,
      aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1};

   // Drive decision for one general port bit under its I/O mode
   function automatic logic [1:0] port_drive(input logic [1:0] mode, input logic value);
      logic [1:0] r;
      r = 2'h0;
      case (mode)
         MODE_PUSH_PULL: r = {value, 1'b1};
         MODE_OPEN_DRAIN: r = {1'b0, ~value};
         MODE_QUASI: r = {1'b0, ~value}; // Weak pull-up left to the pad
         default: r = 2'h0;
      endcase
      return r;
   endfunction : port_drive

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw,
                                            input logic en);
      return en ? nw : old;
   endfunction : merge_byte

   logic rc_osc;
   logic dbg_en;
   logic fuse_en;
   logic [7:0] alt_claim;
   logic [7:0] alt_out;
   logic [7:0] alt_oe;

   assign rc_osc = state_reg.cfg[CFG_RC_OSC_BIT];
   assign dbg_en = state_reg.cfg[CFG_DEBUG_EN_BIT];
   assign fuse_en = state_reg.cfg[CFG_RESET_FUSE_BIT];

   always_comb begin
      alt_claim = 8'h00;
      alt_out = 8'h00;
      alt_oe = 8'h00;
      if (dbg_en && !rc_osc) begin
         // External clock on port4 bit0 keeps debug data on port4 bit1
         alt_claim[PIN_P41] = 1'b1;
         alt_out[PIN_P41] = debug_data_out;
         alt_oe[PIN_P41] = debug_data_oe;
         alt_claim[PIN_P37] = 1'b1;
         alt_out[PIN_P37] = debug_data_out;
         alt_oe[PIN_P37] = debug_data_oe;
      end else if (!rc_osc) begin
         alt_claim[PIN_P41] = 1'b1;
         alt_out[PIN_P41] = osc_amp_out_level;
         alt_oe[PIN_P41] = 1'b1;
      end else if (state_reg.cfg[CFG_DIV_CLOCK_EN_BIT] && !dbg_en) begin
         alt_claim[PIN_P41] = 1'b1;
         alt_out[PIN_P41] = state_reg.div_clk;
         alt_oe[PIN_P41] = 1'b1;
      end
      if (!rc_osc) begin
         alt_claim[PIN_P40] = 1'b1;
      end else if (dbg_en) begin
         alt_claim[PIN_P40] = 1'b1;
         alt_out[PIN_P40] = debug_data_out;
         alt_oe[PIN_P40] = debug_data_oe;
      end
      // Reset and debug clock are inputs only, so the pin is not driven while either one claims it
      alt_claim[PIN_P36] = fuse_en || dbg_en;
      if (state_reg.cfg[CFG_PWM0_EN_BIT]) begin
         alt_claim[PIN_P34] = 1'b1;
         alt_out[PIN_P34] = pwm0_level;
         alt_oe[PIN_P34] = 1'b1;
      end
      if (state_reg.cfg[CFG_PWM1_EN_BIT]) begin
         alt_claim[PIN_P35] = 1'b1;
         alt_out[PIN_P35] = pwm1_level;
         alt_oe[PIN_P35] = 1'b1;
      end
   end

   always_comb begin
      logic [1:0] drv;
      logic [31:0] wd;
      logic [7:0] ra;
      drv = 2'h0;
      wd = 32'h0000_0000;
      ra = 8'h00;
      state_next = state_reg;
      // Write channel: address and data taken in either order, response after both
      if (s_axi_awvalid && !state_reg.aw_held && !state_reg.bvalid) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_reg.w_held && !state_reg.bvalid) begin
         state_next.w_held = 1'b1;
         state_next.w_data = s_axi_wdata;
         state_next.w_strb = s_axi_wstrb;
      end
      if (state_reg.aw_held && state_reg.w_held) begin
         wd = state_reg.w_data;
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = RESP_OKAY;
         case (state_reg.aw_addr)
            ADDR_CONFIG: begin
               if (state_reg.w_strb[0]) begin
                  state_next.cfg = wd[5:0];
               end
            end
            ADDR_PORT_OUT: begin
               state_next.port_out = merge_byte(state_reg.port_out, wd[7:0],
                                                state_reg.w_strb[0]);
            end
            ADDR_PORT_MODE: begin
               state_next.port_mode[7:0] = merge_byte(state_reg.port_mode[7:0], wd[7:0],
                                                      state_reg.w_strb[0]);
               state_next.port_mode[15:8] = merge_byte(state_reg.port_mode[15:8], wd[15:8],
                                                       state_reg.w_strb[1]);
            end
            ADDR_PIN_STATUS, ADDR_PIN_IN: begin
               state_next.bresp = RESP_OKAY; // Read-only, write ignored
            end
            default: begin
               state_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (state_reg.bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end
      // Read channel: one cycle from address to data
      if (s_axi_arvalid && !state_reg.rvalid) begin
         ra = s_axi_araddr;
         state_next.rvalid = 1'b1;
         state_next.rresp = RESP_OKAY;
         case (ra)
            ADDR_CONFIG: state_next.rdata = {26'h0, state_reg.cfg};
            ADDR_PORT_OUT: state_next.rdata = {24'h0, state_reg.port_out};
            ADDR_PORT_MODE: state_next.rdata = {16'h0, state_reg.port_mode};
            ADDR_PIN_STATUS: state_next.rdata = {16'h0, state_reg.pin_oe, alt_claim};
            ADDR_PIN_IN: state_next.rdata = {24'h0, pin_in};
            default: begin
               state_next.rdata = 32'h0000_0000;
               state_next.rresp = RESP_SLVERR;
            end
         endcase
      end else if (state_reg.rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end
      // Toggling each cycle gives the system clock divided by two
      state_next.div_clk = rc_osc ? ~state_reg.div_clk : 1'b0;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (alt_claim[i]) begin
            state_next.pin_out[i] = alt_out[i];
            state_next.pin_oe[i] = alt_oe[i];
         end else begin
            drv = port_drive(state_reg.port_mode[2*i +: 2], state_reg.port_out[i]);
            state_next.pin_out[i] = drv[1];
            state_next.pin_oe[i] = drv[0];
         end
      end
      state_next.osc_in = rc_osc ? 1'b0 : pin_in[PIN_P40];
      if (dbg_en) begin
         state_next.dbg_data = rc_osc ? pin_in[PIN_P40] : pin_in[PIN_P41];
      end else begin
         state_next.dbg_data = 1'b1;
      end
      state_next.dbg_clk = dbg_en ? pin_in[PIN_P36] : 1'b0;
      state_next.rst_pin_n = fuse_en ? pin_in[PIN_P36] : 1'b1;
      state_next.irq0 = pin_in[PIN_P32];
      state_next.irq1 = pin_in[PIN_P33];
      state_next.t0_cnt = state_reg.cfg[CFG_PWM0_EN_BIT] ? 1'b0 : pin_in[PIN_P34];
      state_next.t1_cnt = state_reg.cfg[CFG_PWM1_EN_BIT] ? 1'b0 : pin_in[PIN_P35];
      state_next.aw_rdy = !state_next.aw_held && !state_next.bvalid;
      state_next.w_rdy = !state_next.w_held && !state_next.bvalid;
      state_next.ar_rdy = !state_next.rvalid;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= STATE_RESET;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end
   assign s_axi_awready = state_reg.aw_rdy;
   assign s_axi_wready = state_reg.w_rdy;
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_arready = state_reg.ar_rdy;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rdata = state_reg.rdata;
   assign s_axi_rresp = state_reg.rresp;
   assign pin_out = state_reg.pin_out;
   assign pin_oe = state_reg.pin_oe;
   assign osc_amp_in = state_reg.osc_in;
   assign debug_serial_data = state_reg.dbg_data;
   assign debug_serial_clock = state_reg.dbg_clk;
   assign ext_reset_n = state_reg.rst_pin_n;
   assign ext_irq_zero = state_reg.irq0;
   assign ext_irq_one = state_reg.irq1;
   assign timer0_count_pin = state_reg.t0_cnt;
   assign timer_count_pin = state_reg.t1_cnt;
   a_osc_out_drive: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !rc_osc && !dbg_en |=> pin_oe[PIN_P41])
      else $error("oscillator output pin not driven");
   a_osc_in_route: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !rc_osc |=> osc_amp_in == $past(pin_in[PIN_P40]))
      else $error("oscillator input not routed");
   a_div_clock_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && rc_osc |=> state_reg.div_clk != $past(state_reg.div_clk))
      else $error("divided clock did not toggle");
   a_debug_data_p41: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && dbg_en && !rc_osc |=> debug_serial_data == $past(pin_in[PIN_P41]))
      else $error("debug data not taken from port4 bit1");
   a_debug_data_p40: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && dbg_en && rc_osc |=> debug_serial_data == $past(pin_in[PIN_P40]))
      else $error("debug data not taken from port4 bit0");
   a_reset_pin_idle: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !fuse_en |=> ext_reset_n)
      else $error("reset asserted with fuse off");
   a_reset_pin_low: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && fuse_en && !pin_in[PIN_P36] |=> !ext_reset_n)
      else $error("low reset pin not passed on");
   a_debug_clk_in: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && dbg_en |=> debug_serial_clock == $past(pin_in[PIN_P36]))
      else $error("debug clock not routed");
   a_irq_routes: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en |=> ext_irq_zero == $past(pin_in[PIN_P32]) && ext_irq_one == $past(pin_in[PIN_P33]))
      else $error("interrupt pins not routed");
   a_pwm0_drive: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state_reg.cfg[CFG_PWM0_EN_BIT] |=>
      pin_oe[PIN_P34] && pin_out[PIN_P34] == $past(pwm0_level))
      else $error("timer 0 PWM output not driven");
   a_pwm1_drive: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state_reg.cfg[CFG_PWM1_EN_BIT] |=>
      pin_oe[PIN_P35] && pin_out[PIN_P35] == $past(pwm1_level))
      else $error("timer 1 PWM output not driven");
   a_debug_p37: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && dbg_en && !rc_osc |=> pin_oe[PIN_P37] == $past(debug_data_oe))
      else $error("port3 bit7 debug data drive wrong");
   a_write_resp: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state_reg.aw_held && state_reg.w_held |=> s_axi_bvalid)
      else $error("write response missing");
   c_rc_debug: cover property (@(posedge clk) disable iff (!rst_n) dbg_en && rc_osc);
   c_fuse_reset: cover property (@(posedge clk) disable iff (!rst_n) !ext_reset_n);
   c_div_clock: cover property (@(posedge clk) disable iff (!rst_n) alt_claim[PIN_P41] && rc_osc);
   c_read: cover property (@(posedge clk) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);

endmodule : port_pin_function_select
`default_nettype wire

// ---- sim/pin_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
// Crystal, debug host and reset source seen as drivers on the pads
module pin_far_side (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] host_oe,
   input wire logic [7:0] host_val,
   output logic [7:0] pad
);
   // Released pads float up to the weak pull-up level, never the last value
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) begin
            pad[i] = pin_out[i];
         end else if (host_oe[i]) begin
            pad[i] = host_val[i];
         end else begin
            pad[i] = 1'b1;
         end
      end
   end
endmodule : pin_far_side
`default_nettype wire

// ---- sim/port_pin_function_select_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_select_test;
   import pin_select_pkg::*;
   logic clk = 0, rst_n = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, host_oe = 8'h00, host_val = 8'h00;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, clk_en = 1;
   logic [31:0] wdata = 32'h0;
   logic osc_lvl = 0, dbg_out = 0, dbg_oe = 0, pwm0 = 0, pwm1 = 0, p;
   logic awready, wready, bvalid, arready, rvalid, osc_in, dbg_data, dbg_clk;
   logic rst_pin_n, irq0, irq1, cnt0, cnt1;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] pin_out, pin_oe, pad;
   int errors = 0, n_checks = 0;
   always #20 clk = ~clk;
   port_pin_function_select DUT (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_in(pad), .pin_out(pin_out), .pin_oe(pin_oe), .osc_amp_out_level(osc_lvl),
      .debug_data_out(dbg_out), .debug_data_oe(dbg_oe), .pwm0_level(pwm0),
      .pwm1_level(pwm1), .osc_amp_in(osc_in), .debug_serial_data(dbg_data),
      .debug_serial_clock(dbg_clk), .ext_reset_n(rst_pin_n), .ext_irq_zero(irq0),
      .ext_irq_one(irq1), .timer0_count_pin(cnt0), .timer_count_pin(cnt1));
   pin_far_side far (.pin_out(pin_out), .pin_oe(pin_oe), .host_oe(host_oe),
      .host_val(host_val), .pad(pad));
   task automatic complete_run();
      if (errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic tick(inout int k);
      k++;
      if (k > 60) begin
         errors++;
         complete_run();
      end
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      logic ta, tw, ra, rw, rb;
      k = 0; ta = 0; tw = 0; rb = 0;
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
      while (!(ta && tw)) begin
         @(negedge clk);
         ra = awready; rw = wready;
         @(posedge clk);
         if (!ta && ra) begin awvalid <= 0; ta = 1; end
         if (!tw && rw) begin wvalid <= 0; tw = 1; end
         tick(k);
      end
      bready <= 1;
      while (!rb) begin
         @(negedge clk);
         rb = bvalid;
         if (rb) check("bresp", er, bresp);
         @(posedge clk);
         tick(k);
      end
      bready <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int k;
      logic ra, rv;
      k = 0; ra = 0; rv = 0;
      @(posedge clk);
      araddr <= a; arvalid <= 1;
      while (!ra) begin
         @(negedge clk);
         ra = arready;
         @(posedge clk);
         tick(k);
      end
      arvalid <= 0; rready <= 1;
      while (!rv) begin
         @(negedge clk);
         rv = rvalid;
         if (rv) begin check("rdata", ed, rdata); check("rresp", er, rresp); end
         @(posedge clk);
         tick(k);
      end
      rready <= 0;
   endtask : rd
   // Outputs are registered: three edges cover the pad and config paths
   task automatic settle();
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic host(input logic [7:0] oe, input logic [7:0] v);
      @(posedge clk);
      host_oe <= oe; host_val <= v;
      settle();
   endtask : host
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1;
      rd(ADDR_CONFIG, {26'h0, CFG_RESET_VALUE}, RESP_OKAY);
      rd(ADDR_PORT_OUT, {24'h0, PORT_OUT_RESET}, RESP_OKAY);
      rd(ADDR_PORT_MODE, {16'h0, PORT_MODE_RESET}, RESP_OKAY);
      rd(8'h14, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'h0, RESP_SLVERR);
      host(8'h48, 8'h00);
      check("rst_pin_n", 0, rst_pin_n);
      check("oe6", 0, pin_oe[6]);
      check("irq0", 1, irq0);
      check("irq1", 0, irq1);
      host(8'h4d, 8'h48);
      check("rst_pin_n", 1, rst_pin_n);
      check("irq0", 0, irq0);
      check("irq1", 1, irq1);
      check("osc_in", 0, osc_in);
      host(8'h31, 8'h11);
      check("osc_in", 1, osc_in);
      check("cnt0", 1, cnt0);
      check("cnt1", 0, cnt1);
      check("oe1", 1, pin_oe[1]);
      check("out1", 0, pin_out[1]);
      @(posedge clk);
      osc_lvl <= 1;
      pwm0 <= 1;
      host(8'h00, 8'h00);
      check("out1", 1, pin_out[1]);
      wr(ADDR_PORT_MODE, 32'h1505, RESP_OKAY);
      wr(ADDR_CONFIG, 32'h34, RESP_OKAY);
      settle();
      check("out4", 1, pin_out[4]);
      check("out5", 0, pin_out[5]);
      check("oe45", 3, pin_oe[5:4]);
      check("cnt0", 0, cnt0);
      wr(ADDR_PORT_OUT, 32'hba, RESP_OKAY);
      wr(ADDR_CONFIG, 32'h01, RESP_OKAY);
      settle();
      check("out01", 2, pin_out[1:0]);
      check("oe01", 3, pin_oe[1:0]);
      check("osc_in", 0, osc_in);
      check("out6", 0, pin_out[6]);
      check("oe6", 1, pin_oe[6]);
      check("rst_pin_n", 1, rst_pin_n);
      check("oe23", 1, pin_oe[3:2]);
      check("out2", 0, pin_out[2]);
      wr(ADDR_CONFIG, 32'h09, RESP_OKAY);
      settle();
      p = ~pin_out[1];
      @(negedge clk);
      check("div_clk", p, pin_out[1]);
      check("oe1", 1, pin_oe[1]);
      @(posedge clk);
      dbg_oe <= 1;
      wr(ADDR_CONFIG, 32'h02, RESP_OKAY);
      host(8'h40, 8'h00);
      check("dbg_clk", 0, dbg_clk);
      check("oe6", 0, pin_oe[6]);
      check("oe17", 8'h82, pin_oe & 8'h82);
      check("out17", 0, pin_out & 8'h82);
      @(posedge clk);
      dbg_out <= 1;
      host(8'h40, 8'h40);
      check("dbg_clk", 1, dbg_clk);
      check("out17", 8'h82, pin_out & 8'h82);
      wr(ADDR_CONFIG, 32'h03, RESP_OKAY);
      settle();
      check("out0", 1, pin_out[0]);
      check("oe0", 1, pin_oe[0]);
      @(posedge clk);
      dbg_oe <= 0;
      host(8'h01, 8'h00);
      check("dbg_data", 0, dbg_data);
      check("oe0", 0, pin_oe[0]);
      // With the enable low the debug clock must hold its last level
      @(posedge clk);
      clk_en <= 0;
      host(8'h40, 8'h00);
      check("dbg_clk_frozen", 1, dbg_clk);
      @(posedge clk);
      clk_en <= 1;
      settle();
      check("dbg_clk", 0, dbg_clk);
      @(posedge clk);
      rst_n <= 0;
      repeat (3) @(posedge clk);
      rst_n <= 1;
      rd(ADDR_CONFIG, {26'h0, CFG_RESET_VALUE}, RESP_OKAY);
      complete_run();
   end
endmodule : port_pin_function_select_test
`default_nettype wire
